// ### core/lte_pkg.sv
// Shared constants for the logic analyzer trigger engine
package lte_pkg;
   // Build-time sizes, fixed for this core
   localparam int NUM_UNITS = 4; // Trigger units in the core
   localparam int UNIT_W = 8; // Signals per trigger unit
   localparam int NUM_EXPR = 2; // Trigger expression slots
   localparam int MAX_SEQ = 4; // Sequence depth, one of 1,2,4,8,16
   localparam int SEQ_W = 2; // Bits to index a sequence step
   localparam int EVT_W = 16; // Event counter, max count 65535
   localparam int FIN_W = 17; // Final count register width
   localparam int TRACE_W = 32; // Trace signals served by this core
   localparam int NUM_CORES = 1; // Cores in the design
   localparam logic FINAL_CNT_EN = 1'b1; // Final trigger counter built in
   localparam logic [16:0] FINAL_CAP = 17'h00400; // Final counter capacity
   localparam logic TRIG_POL = 1'b1; // Trigger out active level
   localparam logic [31:0] SIGNATURE = 32'h1234abcd; // Arbitrary build signature
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_EXPR_EN = 8'h04;
   localparam logic [7:0] REG_FINAL = 8'h08;
   localparam logic [7:0] REG_PULSE = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_SIG = 8'h14;
   localparam logic [7:0] REG_SEQLEN = 8'h18;
   localparam logic [1:0] PAGE_STEP = 2'h1; // paddr[7:6] of step words
   localparam logic [1:0] PAGE_UNIT = 2'h2; // paddr[7:6] of unit words
   // Field positions
   localparam int CTRL_ARM = 0;
   localparam int CTRL_TOEN = 1;
   localparam int STEP_MASK = 0; // Unit select, NUM_UNITS bits
   localparam int STEP_OP = 4; // Combine operator, 2 bits
   localparam int STEP_INV = 6; // Invert combined condition
   localparam int STEP_MODE = 7; // Step mode, 2 bits
   localparam int STEP_CNT = 16; // Count target, EVT_W bits
   localparam int UOP_SERLEN = 8; // Serial pattern length, 4 bits
   // Reset values
   localparam logic [16:0] RST_FINAL = 17'h00001;
   localparam logic [15:0] RST_PULSE = 16'h0000;
   localparam logic [7:0] RST_SEQLEN = 8'h11;
   localparam logic [1:0] RST_EXPR_EN = 2'h3;
   // Unit comparator codes
   localparam logic [3:0] UOP_EQ = 4'h0;
   localparam logic [3:0] UOP_NE = 4'h1;
   localparam logic [3:0] UOP_GT = 4'h2;
   localparam logic [3:0] UOP_GE = 4'h3;
   localparam logic [3:0] UOP_LT = 4'h4;
   localparam logic [3:0] UOP_LE = 4'h5;
   localparam logic [3:0] UOP_RISE = 4'h6;
   localparam logic [3:0] UOP_FALL = 4'h7;
   localparam logic [3:0] UOP_SER = 4'h8;
   // Combine operators and step modes
   localparam logic [1:0] CMB_AND = 2'h0;
   localparam logic [1:0] CMB_OR = 2'h1;
   localparam logic [1:0] CMB_XOR = 2'h2;
   localparam logic [1:0] MODE_THEN = 2'h0;
   localparam logic [1:0] MODE_NEXT = 2'h1;
   localparam logic [1:0] MODE_CNT = 2'h2;
   localparam logic [1:0] MODE_CONSEC = 2'h3;
endpackage

// ### core/lte_trig_unit.sv
// One trigger unit: compares a signal group against a value
`timescale 1ns/1ps
`default_nettype none
module lte_trig_unit (
   input wire logic ref_clk, // Sample clock
   input wire logic nrst, // Async reset, active low
   input wire logic sampleEn, // Sample enable
   input wire logic [lte_pkg::UNIT_W-1:0] sig, // Probed signals
   input wire logic [lte_pkg::UNIT_W-1:0] value, // Compare value
   input wire logic [3:0] op, // Comparator code
   input wire logic [3:0] serLen, // Serial pattern length
   output logic hit // Condition true this sample
);
   logic [lte_pkg::UNIT_W-1:0] prev_r; // Last sampled value
   logic [lte_pkg::UNIT_W-1:0] hist_r; // Serial bit history
   logic [lte_pkg::UNIT_W-1:0] histNow; // History with current bit
   logic [lte_pkg::UNIT_W-1:0] lenMask; // Pattern bits in use

   // History keeps newest bit at index 0
   assign histNow = {hist_r[lte_pkg::UNIT_W-2:0], sig[0]};
   assign lenMask = ~({lte_pkg::UNIT_W{1'b1}} << serLen);

   // Past samples, held while sampling is paused
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prev_r <= '0;
         hist_r <= '0;
      end else if (sampleEn) begin
         prev_r <= sig;
         hist_r <= histNow;
      end
   end

   // Comparator select
   always_comb begin
      case (op)
         lte_pkg::UOP_EQ: hit = (sig == value);
         lte_pkg::UOP_NE: hit = (sig != value);
         lte_pkg::UOP_GT: hit = (sig > value);
         lte_pkg::UOP_GE: hit = (sig >= value);
         lte_pkg::UOP_LT: hit = (sig < value);
         lte_pkg::UOP_LE: hit = (sig <= value);
         // Edge on any bit selected by the value
         lte_pkg::UOP_RISE: hit = |(sig & ~prev_r & value);
         lte_pkg::UOP_FALL: hit = |(~sig & prev_r & value);
         // Oldest bit matches the top pattern bit, first bit first
         lte_pkg::UOP_SER: hit = (((histNow ^ value) & lenMask) == '0);
         default: hit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ### core/lte_trig_engine.sv
// Trigger engine top: units, sequenced expressions, final trigger, APB
//
// Behaviour
// - consecutive count restarts on any false cycle
// - count term needs target hits before advancing
// - sequence depth fixed at build, max 16
// - event counter sized at build, up to 65535
// - optional final counter, capacity 2 to 65536
// - without final counter, fire on first occurrence
// - final count reload refused above capacity
// - trigger out driven at build polarity
// - trigger out held minimum sample cycles
// - disabled expressions never reach final trigger
// - units and operators reprogrammable at run time
// - one to 512 trace signals per core
// - up to 4096 trigger inputs, 256 per unit
// - one to 16 units and expressions
// - single sample clock and sample enable
// - one to 15 cores per design
// - used steps clamped to built depth
// - build signature readable by host
// - next step must follow immediately
// - serial compare matches pattern bit by bit
// - wait step holds until condition true
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lte_trig_engine (
   input wire logic ref_clk, // Sample clock, 200 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic sampleEn, // Sample enable from user design
   input wire logic [lte_pkg::NUM_UNITS*lte_pkg::UNIT_W-1:0] trigIn, // Probes
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic trigOut // Trigger out net
);
   localparam int NSTEP = lte_pkg::NUM_EXPR * lte_pkg::MAX_SEQ; // Step words

   // Software state
   logic arm_r; // Trigger engine armed
   logic toEn_r; // Trigger out enabled
   logic [lte_pkg::NUM_EXPR-1:0] exprEn_r; // Expression enables
   logic [16:0] finalCount_r; // Final trigger count
   logic [15:0] minPulse_r; // Minimum pulse in samples
   logic [7:0] seqLen_r; // Used steps, one nibble per expression
   logic [31:0] stepCfg_r [NSTEP]; // Step configuration words
   logic [lte_pkg::UNIT_W-1:0] unitVal_r [lte_pkg::NUM_UNITS]; // Values
   logic [11:0] unitOp_r [lte_pkg::NUM_UNITS]; // Comparator and length
   // Engine state
   logic [lte_pkg::NUM_UNITS-1:0] unitHit; // Unit conditions
   logic [lte_pkg::SEQ_W-1:0] step_r [lte_pkg::NUM_EXPR]; // Current step
   logic [lte_pkg::EVT_W-1:0] evt_r [lte_pkg::NUM_EXPR]; // Event counters
   logic [lte_pkg::NUM_EXPR-1:0] exprHit; // Expression completes
   logic [lte_pkg::NUM_EXPR-1:0] stepCond; // Current step condition
   logic [16:0] finCnt_r; // Occurrences of combined output
   logic combined; // Any enabled expression completes
   logic fire; // Final trigger event
   logic triggered_r; // Final trigger seen since arming
   logic trigAct_r; // Trigger pulse active, set on fire even while toEn_r is low
   logic [15:0] hold_r; // Remaining pulse samples
   // Bus
   logic setup; // APB setup cycle
   logic wrEn; // Write commits this edge
   logic [31:0] rdData; // Read mux
   logic rdErr; // Error for the current request
   logic armSet; // Software arms this edge

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // Build limits checked against the fixed sizes
   a_build_limits: assert property (
      lte_pkg::MAX_SEQ <= 16 && lte_pkg::EVT_W <= 16 && lte_pkg::NUM_UNITS <= 16
      && lte_pkg::NUM_EXPR <= 16 && lte_pkg::UNIT_W <= 256
      && lte_pkg::NUM_UNITS * lte_pkg::UNIT_W <= 4096 && lte_pkg::TRACE_W <= 512
      && lte_pkg::NUM_CORES <= 15 && lte_pkg::FINAL_CAP <= 17'h10000)
      else $error("build sizes out of range");

   // Trigger units, one per signal group
   generate
      for (genvar u = 0; u < lte_pkg::NUM_UNITS; u++) begin : g_unit
         lte_trig_unit unit_i (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .sampleEn(sampleEn),
            .sig(trigIn[u*lte_pkg::UNIT_W +: lte_pkg::UNIT_W]),
            .value(unitVal_r[u]),
            .op(unitOp_r[u][3:0]),
            .serLen(unitOp_r[u][lte_pkg::UOP_SERLEN +: 4]),
            .hit(unitHit[u])
         );
      end
   endgenerate

   // Sequence engine, one per expression slot
   generate
      for (genvar e = 0; e < lte_pkg::NUM_EXPR; e++) begin : g_expr
         localparam int BASE = e * lte_pkg::MAX_SEQ; // First step word
         logic [31:0] cfg; // Active step word
         logic [lte_pkg::NUM_UNITS-1:0] mask; // Units used by the step
         logic [1:0] mode; // Step mode
         logic [2:0] len; // Programmed step count
         logic [lte_pkg::SEQ_W-1:0] last; // Final used step
         logic raw; // Combined unit condition
         logic reached; // Count target met this sample
         logic adv; // Step satisfied, move on

         assign cfg = stepCfg_r[BASE + int'(step_r[e])];
         assign mask = cfg[lte_pkg::STEP_MASK +: lte_pkg::NUM_UNITS];
         assign mode = cfg[lte_pkg::STEP_MODE +: 2];
         assign len = seqLen_r[4*e +: 3];

         // Steps beyond the built depth are never entered
         always_comb begin
            if (len == 3'h0) begin
               last = '0;
            end else if (int'(len) > lte_pkg::MAX_SEQ) begin
               last = lte_pkg::SEQ_W'(lte_pkg::MAX_SEQ - 1);
            end else begin
               last = lte_pkg::SEQ_W'(len - 3'h1);
            end
         end

         // Operators between units come from the step word
         always_comb begin
            case (cfg[lte_pkg::STEP_OP +: 2])
               lte_pkg::CMB_AND: raw = &(unitHit | ~mask);
               lte_pkg::CMB_OR: raw = |(unitHit & mask);
               lte_pkg::CMB_XOR: raw = ^(unitHit & mask);
               default: raw = 1'b0;
            endcase
         end
         assign stepCond[e] = raw ^ cfg[lte_pkg::STEP_INV];

         // Target 0 behaves as 1
         assign reached = ({1'b0, evt_r[e]} + 17'h1)
            >= {1'b0, cfg[lte_pkg::STEP_CNT +: lte_pkg::EVT_W]};
         assign adv = arm_r && sampleEn && stepCond[e]
            && (mode == lte_pkg::MODE_THEN || mode == lte_pkg::MODE_NEXT || reached);
         assign exprHit[e] = adv && (step_r[e] == last);

         // Step and counter advance only on enabled samples
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               step_r[e] <= '0;
               evt_r[e] <= '0;
            end else if (!arm_r) begin
               step_r[e] <= '0;
               evt_r[e] <= '0;
            end else if (sampleEn) begin
               if (adv) begin
                  step_r[e] <= (step_r[e] == last) ? '0 : step_r[e] + 1'b1;
                  evt_r[e] <= '0;
               end else if (stepCond[e]) begin
                  evt_r[e] <= evt_r[e] + 1'b1;
               end else if (mode == lte_pkg::MODE_NEXT && step_r[e] != '0) begin
                  step_r[e] <= '0;
               end else if (mode == lte_pkg::MODE_CONSEC) begin
                  evt_r[e] <= '0;
               end
            end
         end

         sequence s_gap;
            arm_r && sampleEn && !stepCond[e];
         endsequence
         a_consec_restart: assert property (
            (s_gap and mode == lte_pkg::MODE_CONSEC) |=> evt_r[e] == '0)
            else $error("consecutive count kept after gap");
         a_count_target: assert property (
            (adv && mode == lte_pkg::MODE_CNT && step_r[e] != last)
            |=> step_r[e] == $past(step_r[e]) + 1'b1 && evt_r[e] == '0)
            else $error("count step did not advance on target");
         a_count_early: assert property (
            (arm_r && sampleEn && stepCond[e] && mode == lte_pkg::MODE_CNT && !reached)
            |=> step_r[e] == $past(step_r[e]))
            else $error("count step left before target");
         a_next_break: assert property (
            (s_gap and mode == lte_pkg::MODE_NEXT && step_r[e] != '0)
            |=> step_r[e] == '0)
            else $error("next step did not fall back");
         a_wait_hold: assert property (
            (s_gap and mode == lte_pkg::MODE_THEN) |=> $stable(step_r[e]))
            else $error("wait step moved without condition");
         a_gate_hold: assert property (
            (arm_r && !sampleEn) ##1 arm_r |-> $stable(step_r[e]) && $stable(evt_r[e]))
            else $error("sequence moved without sample enable");
         a_depth_clamp: assert property (
            int'(step_r[e]) < lte_pkg::MAX_SEQ && step_r[e] <= last || $changed(seqLen_r))
            else $error("step beyond used depth");
      end
   endgenerate

   // Only enabled expressions feed the final trigger
   assign combined = |(exprHit & exprEn_r);
   // Without the counter the first occurrence fires
   assign fire = !triggered_r && combined
      && (!lte_pkg::FINAL_CNT_EN || finCnt_r + 17'h1 >= finalCount_r);

   // Final occurrence counter and sticky triggered flag
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         finCnt_r <= '0;
         triggered_r <= 1'b0;
      end else if (fire) begin
         // Set wins over a re-arm in the same cycle
         finCnt_r <= '0;
         triggered_r <= 1'b1;
      end else if (armSet || !arm_r) begin
         finCnt_r <= '0;
         triggered_r <= armSet ? 1'b0 : triggered_r;
      end else if (combined && !triggered_r) begin
         finCnt_r <= finCnt_r + 17'h1;
      end
   end

   // Trigger out pulse stretched to the minimum width
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         trigAct_r <= 1'b0;
         hold_r <= '0;
         trigOut <= ~lte_pkg::TRIG_POL;
      end else if (fire) begin
         trigAct_r <= 1'b1;
         hold_r <= minPulse_r;
         trigOut <= toEn_r ? lte_pkg::TRIG_POL : ~lte_pkg::TRIG_POL;
      end else if (trigAct_r && sampleEn) begin
         // Width counts sample cycles, so pauses stretch it
         if (hold_r <= 16'h0001) begin
            trigAct_r <= 1'b0;
            trigOut <= ~lte_pkg::TRIG_POL;
         end else begin
            hold_r <= hold_r - 16'h0001;
         end
      end else if (!trigAct_r || !toEn_r) begin
         trigOut <= ~lte_pkg::TRIG_POL;
      end
   end

   sequence s_fire_on;
      fire && toEn_r;
   endsequence
   a_out_level: assert property (
      s_fire_on |=> trigAct_r && trigOut == lte_pkg::TRIG_POL)
      else $error("trigger out not at active level");
   a_pulse_hold: assert property (
      (trigAct_r && hold_r > 16'h0001) |=> trigAct_r)
      else $error("trigger out released too early");
   a_pulse_end: assert property (
      (trigAct_r && sampleEn && !fire && hold_r <= 16'h0001)
      |=> !trigAct_r && trigOut == ~lte_pkg::TRIG_POL)
      else $error("trigger out not released");
   a_fire_source: assert property (
      fire |-> |(exprHit & exprEn_r) && arm_r)
      else $error("final trigger without enabled expression");
   a_final_range: assert property (
      finalCount_r <= lte_pkg::FINAL_CAP)
      else $error("final count above capacity");

   // APB handshake: one wait-free access phase
   assign setup = psel && !penable;
   assign wrEn = psel && penable && pready && pwrite && !pslverr;
   assign armSet = wrEn && paddr == lte_pkg::REG_CTRL && pwdata[lte_pkg::CTRL_ARM];

   // Read data and error decided in the setup cycle
   always_comb begin
      rdData = 32'h00000000;
      rdErr = 1'b0;
      if (paddr[7:6] == lte_pkg::PAGE_STEP) begin
         if (int'(paddr[5:2]) < NSTEP) begin
            rdData = stepCfg_r[paddr[4:2]];
         end else begin
            rdErr = 1'b1;
         end
      end else if (paddr[7:6] == lte_pkg::PAGE_UNIT) begin
         if (int'(paddr[5:3]) >= lte_pkg::NUM_UNITS) begin
            rdErr = 1'b1;
         end else if (paddr[2]) begin
            rdData = {20'h00000, unitOp_r[paddr[4:3]]};
         end else begin
            rdData = {24'h000000, unitVal_r[paddr[4:3]]};
         end
      end else begin
         case (paddr)
            lte_pkg::REG_CTRL: rdData = {30'h00000000, toEn_r, arm_r};
            lte_pkg::REG_EXPR_EN: rdData = {30'h00000000, exprEn_r};
            lte_pkg::REG_FINAL: rdData = {15'h0000, finalCount_r};
            lte_pkg::REG_PULSE: rdData = {16'h0000, minPulse_r};
            lte_pkg::REG_STATUS: rdData = {16'h0000, 4'h0, step_r[1], step_r[0],
               5'h00, trigAct_r, triggered_r, arm_r};
            lte_pkg::REG_SIG: rdData = lte_pkg::SIGNATURE;
            lte_pkg::REG_SEQLEN: rdData = {24'h000000, seqLen_r};
            default: rdErr = 1'b1;
         endcase
      end
      // Refused writes: oversize final count, enables while armed
      if (pwrite && paddr == lte_pkg::REG_FINAL && pwdata[16:0] > lte_pkg::FINAL_CAP) begin
         rdErr = 1'b1;
      end
      if (pwrite && paddr == lte_pkg::REG_EXPR_EN && arm_r) begin
         rdErr = 1'b1;
      end
   end

   // Bus answer flops
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && rdErr;
         prdata <= (setup && !pwrite) ? rdData : 32'h00000000;
      end
   end

   // Control registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         arm_r <= 1'b0;
         toEn_r <= 1'b0;
         exprEn_r <= lte_pkg::RST_EXPR_EN;
         finalCount_r <= lte_pkg::RST_FINAL;
         minPulse_r <= lte_pkg::RST_PULSE;
         seqLen_r <= lte_pkg::RST_SEQLEN;
      end else if (wrEn) begin
         case (paddr)
            lte_pkg::REG_CTRL: begin
               arm_r <= pwdata[lte_pkg::CTRL_ARM];
               toEn_r <= pwdata[lte_pkg::CTRL_TOEN];
            end
            lte_pkg::REG_EXPR_EN: exprEn_r <= pwdata[lte_pkg::NUM_EXPR-1:0];
            lte_pkg::REG_FINAL: finalCount_r <= pwdata[16:0];
            lte_pkg::REG_PULSE: minPulse_r <= pwdata[15:0];
            lte_pkg::REG_SEQLEN: seqLen_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Step and unit configuration tables
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NSTEP; i++) begin
            stepCfg_r[i] <= 32'h00000000;
         end
         for (int i = 0; i < lte_pkg::NUM_UNITS; i++) begin
            unitVal_r[i] <= '0;
            unitOp_r[i] <= 12'h000;
         end
      end else if (wrEn && paddr[7:6] == lte_pkg::PAGE_STEP) begin
         stepCfg_r[paddr[4:2]] <= pwdata;
      end else if (wrEn && paddr[7:6] == lte_pkg::PAGE_UNIT) begin
         if (paddr[2]) begin
            unitOp_r[paddr[4:3]] <= pwdata[11:0];
         end else begin
            unitVal_r[paddr[4:3]] <= pwdata[lte_pkg::UNIT_W-1:0];
         end
      end
   end

   a_bus_answer: assert property (
      (setup && pwrite && paddr == lte_pkg::REG_FINAL
      && pwdata[16:0] > lte_pkg::FINAL_CAP) |=> pready && pslverr ##1 $stable(finalCount_r))
      else $error("oversize final count not refused");
endmodule
`default_nettype wire

// ### bench/lte_user_logic.sv
// Model of the probed user logic feeding the trigger engine
`timescale 1ns/1ps
`default_nettype none
module lte_user_logic (
   input wire logic ref_clk, // Sample clock
   input wire logic nrst, // Reset, active low
   input wire logic hitReq, // Bench asks for a unit0 match
   input wire logic holdReq, // Bench asks for a paused sample
   output logic sampleEn, // Single sample enable
   output logic [31:0] trigIn // Probed signals
);
   logic [7:0] noise_r; // Free running filler
   // Filler moves every cycle so stale values never look stable
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         noise_r <= 8'h00;
      end else begin
         noise_r <= noise_r + 8'h01;
      end
   end
   // Even filler never equals 0x05, masked filler never 0xff
   assign trigIn[7:0] = hitReq ? 8'h05 : {noise_r[6:0], 1'b0};
   assign trigIn[31:8] = {3{noise_r & 8'h7f}};
   assign sampleEn = !holdReq;
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the trigger engine
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk = 1'b0; // 200 MHz sample clock
   logic nrst = 1'b0; // Reset, active low
   logic hitReq = 1'b0; // Unit0 match request
   logic holdReq = 1'b0; // Sample pause request
   logic sampleEn, pready, pslverr, trigOut; // Model and engine outputs
   logic [31:0] trigIn, prdata; // Probes, read data
   logic psel = 1'b0; // APB select
   logic penable = 1'b0; // APB access phase
   logic pwrite = 1'b0; // APB direction
   logic [7:0] paddr = 8'h00; // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   int fails = 0; // Mismatches
   int checkCount = 0; // Comparisons
   int f, w; // First trigger cycle, pulse width
   always #2.5 ref_clk = ~ref_clk;
   lte_user_logic lte_user_logic_i (.ref_clk(ref_clk), .nrst(nrst), .hitReq(hitReq),
      .holdReq(holdReq), .sampleEn(sampleEn), .trigIn(trigIn));
   lte_trig_engine lte_trig_engine_i (.ref_clk(ref_clk), .nrst(nrst), .sampleEn(sampleEn),
      .trigIn(trigIn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigOut(trigOut));
   // Verdict and end of run
   task automatic tallyAndFinish();
      if (fails == 0 && checkCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compare seen against expected
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checkCount++;
      if (s !== x) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) fails++;
   endtask
   // Write and check the error response
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // Read and check data and error response
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // Program expression 0, arm, play a hit pattern, measure trigger out
   task automatic run(input logic [31:0] s0, input logic [31:0] s1, input logic [7:0] sq,
      input logic [1:0] en, input logic [16:0] fin, input logic [15:0] pat,
      input logic [15:0] hold, output int first, output int width);
      first = -1;
      width = 0;
      wr(lte_pkg::REG_CTRL, 32'h0, 1'b0);
      wr(8'h40, s0, 1'b0);
      wr(8'h44, s1, 1'b0);
      wr(lte_pkg::REG_SEQLEN, {24'h0, sq}, 1'b0);
      wr(lte_pkg::REG_EXPR_EN, {30'h0, en}, 1'b0);
      wr(lte_pkg::REG_FINAL, {15'h0, fin}, 1'b0);
      wr(lte_pkg::REG_CTRL, 32'h3, 1'b0);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         hitReq <= pat[i];
         holdReq <= hold[i];
         @(negedge ref_clk);
         // Unknown counts as active so it cannot pass a quiet run
         if (trigOut !== 1'b0) begin
            if (first < 0) first = i;
            width++;
         end
      end
   endtask
   // Hang guard, far beyond the expected run length
   initial begin
      #50000;
      fails++;
      tallyAndFinish();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(lte_pkg::REG_SIG, lte_pkg::SIGNATURE, 1'b0);
      rd(lte_pkg::REG_SEQLEN, {24'h0, lte_pkg::RST_SEQLEN}, 1'b0);
      rd(lte_pkg::REG_FINAL, {15'h0, lte_pkg::RST_FINAL}, 1'b0);
      rd(8'h1c, 32'h0, 1'b1);
      wr(lte_pkg::REG_FINAL, {15'h0, lte_pkg::FINAL_CAP} + 32'h1, 1'b1);
      rd(lte_pkg::REG_FINAL, {15'h0, lte_pkg::RST_FINAL}, 1'b0);
      wr(lte_pkg::REG_FINAL, {15'h0, lte_pkg::FINAL_CAP}, 1'b0);
      wr(8'h80, 32'h5, 1'b0);
      wr(8'h88, 32'hff, 1'b0);
      wr(8'h50, 32'h2, 1'b0);
      wr(lte_pkg::REG_PULSE, 32'h2, 1'b0);
      run(32'h1, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0008, 16'h0, f, w);
      chk(f, 32'd4);
      chk(w, 32'd2);
      wr(lte_pkg::REG_EXPR_EN, 32'h1, 1'b1);
      wr(lte_pkg::REG_PULSE, 32'h0, 1'b0);
      run(32'h1, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0001, 16'h0, f, w);
      chk(f, 32'd1);
      chk(w, 32'd1);
      run(32'h0002_0101, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0005, 16'h0, f, w);
      chk(f, 32'd3);
      run(32'h0003_0181, 32'h0, 8'h11, 2'h1, 17'h1, 16'h003b, 16'h0, f, w);
      chk(f, 32'd6);
      run(32'h1, 32'h81, 8'h12, 2'h1, 17'h1, 16'h000d, 16'h0, f, w);
      chk(f, 32'd4);
      run(32'h1, 32'h0, 8'h11, 2'h1, 17'h2, 16'h0006, 16'h0, f, w);
      chk(f, 32'd3);
      run(32'h1, 32'h0, 8'h11, 2'h2, 17'h1, 16'h0001, 16'h0, f, w);
      chk(f, 32'hffffffff);
      run(32'h1, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0002, 16'h0002, f, w);
      chk(f, 32'hffffffff);
      // OR of units 0 and 1: unit1 never matches, so AND could not fire
      run(32'h0000_0013, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0004, 16'h0, f, w);
      chk(f, 32'd3);
      // Inverted condition is true at once while unit0 is idle
      run(32'h0000_0041, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0000, 16'h0, f, w);
      chk(f, 32'd0);
      // Unit0 as serial compare of pattern 101 on bit0, length 3
      wr(8'h84, 32'h308, 1'b0);
      run(32'h1, 32'h0, 8'h11, 2'h1, 17'h1, 16'h0005, 16'h0, f, w);
      chk(f, 32'd3);
      rd(lte_pkg::REG_STATUS, 32'h3, 1'b0);
      // Re-arm with trigger out disabled: event seen, pin stays low
      wr(8'h84, 32'h0, 1'b0);
      wr(lte_pkg::REG_CTRL, 32'h1, 1'b0);
      @(posedge ref_clk);
      hitReq <= 1'b1;
      @(posedge ref_clk);
      hitReq <= 1'b0;
      @(negedge ref_clk);
      chk({31'h0, trigOut}, 32'h0);
      rd(lte_pkg::REG_STATUS, 32'h3, 1'b0);
      tallyAndFinish();
   end
endmodule
`default_nettype wire
